// [bench/iepx_core_model.sv]
// Behavioural processor core that vectors and returns on bench command
`timescale 1ns/10ps
`default_nettype none
module iepx_core_model (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // Controller side
  input wire logic irq_req_in,
  output logic irq_ack_out,
  output logic irq_return_out,
  // Bench commands
  input wire logic ack_cmd_in,
  input wire logic ret_cmd_in
);
  // One-cycle pulses; a vector is only taken while a request is shown
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_ack_out <= 1'b0;
      irq_return_out <= 1'b0;
    end else begin
      irq_ack_out <= ack_cmd_in & irq_req_in;
      irq_return_out <= ret_cmd_in;
    end
  end
endmodule
`default_nettype wire

// [bench/test_iepx_irq_ctrl.sv]
// Self-checking bench for the interrupt enable, priority and external input block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module test_iepx_irq_ctrl;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [7:0] pins = 8'hff;
  logic [12:0] fl = 13'h0000;
  logic ack_cmd = 1'b0;
  logic ret_cmd = 1'b0;
  logic ack;
  logic ret;
  logic req;
  logic high;
  logic [3:0] id;
  int n_mismatch = 0;
  int n_tests = 0;
  // Enable bit (extended byte high, basic byte low) and order number per flag
  logic [15:0] en_tab [13] = '{16'h0002, 16'h0008, 16'h0010, 16'h0020, 16'h0020,
    16'h0040, 16'h0100, 16'h0800, 16'h1000, 16'h2000, 16'h2000, 16'h8000, 16'h8000};
  logic [3:0] id_tab [13] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h5, 4'h6, 4'h7, 4'ha, 4'hb,
    4'hc, 4'hc, 4'he, 4'he};

  // 20 MHz system clock
  always #25 clk = ~clk;

  iepx_irq_ctrl u_dut (
    .clock_in(clk), .rstn_in(rstn),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .port0_pins_in(pins),
    .timer_zero_flag_in(fl[0]), .timer_one_flag_in(fl[1]),
    .async_serial_flag_in(fl[2]), .timer_two_low_overflow_in(fl[3]),
    .timer_two_high_overflow_in(fl[4]), .serial_periph_flag_in(fl[5]),
    .two_wire_flag_in(fl[6]), .converter_done_flag_in(fl[7]),
    .counter_array_flag_in(fl[8]), .comparator_rise_flag_in(fl[9]),
    .comparator_fall_flag_in(fl[10]), .timer_three_low_overflow_in(fl[11]),
    .timer_three_high_overflow_in(fl[12]),
    .irq_ack_in(ack), .irq_return_in(ret),
    .irq_req_out(req), .irq_id_out(id), .irq_high_out(high)
  );

  iepx_core_model u_core (
    .clock_in(clk), .rstn_in(rstn), .irq_req_in(req), .irq_ack_out(ack),
    .irq_return_out(ret), .ack_cmd_in(ack_cmd), .ret_cmd_in(ret_cmd)
  );

  // Register port cycles: one-cycle strobes, read data in the next cycle only
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask

  // Pins need two edges to reach the request, flags one; three gives margin
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Id and level only mean something while a request stands
  task automatic req_chk(input logic r, input logic [3:0] i, input logic h);
    settle();
    if (r) `CHK({req, id, high}, {r, i, h})
    else `CHK(req, 1'b0)
  endtask

  // Ask the core model to vector (1) or return (0)
  task automatic core(input logic vec);
    @(posedge clk);
    if (vec) ack_cmd <= 1'b1;
    else ret_cmd <= 1'b1;
    @(posedge clk);
    ack_cmd <= 1'b0;
    ret_cmd <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic stop_test;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(iepx_pkg::OFS_IE, 8'h00);
    rd_chk(iepx_pkg::OFS_IP, 8'h80);
    rd_chk(iepx_pkg::OFS_CFG, 8'h01);
    rd_chk(iepx_pkg::OFS_EIE, 8'h00);
    rd_chk(iepx_pkg::OFS_EIP, 8'h00);
    // Reserved extended bits are refused; unmapped place reads zero
    wr_reg(iepx_pkg::OFS_EIE, 8'hff);
    rd_chk(iepx_pkg::OFS_EIE, 8'hb9);
    wr_reg(iepx_pkg::OFS_EIP, 8'hff);
    rd_chk(iepx_pkg::OFS_EIP, 8'hb9);
    wr_reg(iepx_pkg::OFS_EIE, 8'h00);
    wr_reg(iepx_pkg::OFS_EIP, 8'h00);
    wr_reg(8'h10, 8'h5a);
    rd_chk(8'h10, 8'h00);
    // Every source flag: global off, all other enables, then its own enable
    for (int i = 0; i < 13; i++) begin
      fl <= 13'h0001 << i;
      wr_reg(iepx_pkg::OFS_IE, en_tab[i][7:0]);
      wr_reg(iepx_pkg::OFS_EIE, en_tab[i][15:8]);
      req_chk(1'b0, 4'h0, 1'b0);
      wr_reg(iepx_pkg::OFS_IE, 8'hff & ~en_tab[i][7:0]);
      wr_reg(iepx_pkg::OFS_EIE, 8'hb9 & ~en_tab[i][15:8]);
      req_chk(1'b0, 4'h0, 1'b0);
      wr_reg(iepx_pkg::OFS_IE, 8'h80 | en_tab[i][7:0]);
      wr_reg(iepx_pkg::OFS_EIE, en_tab[i][15:8]);
      req_chk(1'b1, id_tab[i], 1'b0);
    end
    fl <= 13'h0003;
    wr_reg(iepx_pkg::OFS_EIE, 8'h00);
    // Timer 0 and timer 1 together: order, levels, nesting
    wr_reg(iepx_pkg::OFS_IE, 8'h8a);
    req_chk(1'b1, 4'h1, 1'b0);
    wr_reg(iepx_pkg::OFS_IP, 8'h08);
    rd_chk(iepx_pkg::OFS_IP, 8'h88);
    req_chk(1'b1, 4'h3, 1'b1);
    wr_reg(iepx_pkg::OFS_IP, 8'h02);
    req_chk(1'b1, 4'h1, 1'b1);
    core(1'b1);
    req_chk(1'b0, 4'h0, 1'b0);
    fl <= 13'h0002;
    core(1'b0);
    req_chk(1'b1, 4'h3, 1'b0);
    core(1'b1);
    fl <= 13'h0003;
    req_chk(1'b1, 4'h1, 1'b1);
    core(1'b1);
    core(1'b0);
    core(1'b0);
    fl <= 13'h0000;
    wr_reg(iepx_pkg::OFS_IE, 8'h00);
    wr_reg(iepx_pkg::OFS_IP, 8'h00);
    // Input 0 on pin 5 active high, input 1 stays on pin 0 active low
    pins <= 8'hdf;
    wr_reg(iepx_pkg::OFS_CFG, 8'h0d);
    rd_chk(iepx_pkg::OFS_CFG, 8'h0d);
    pins <= 8'hff;
    settle();
    rd_chk(iepx_pkg::OFS_TIMER_CONTROL_REG, 8'h02);
    pins <= 8'hdd;
    settle();
    rd_chk(iepx_pkg::OFS_TIMER_CONTROL_REG, 8'h00);
    // Edge mode latches and clears on vectoring
    wr_reg(iepx_pkg::OFS_TIMER_CONTROL_REG, 8'h01);
    pins <= 8'hfd;
    settle();
    rd_chk(iepx_pkg::OFS_TIMER_CONTROL_REG, 8'h03);
    pins <= 8'hdd;
    settle();
    rd_chk(iepx_pkg::OFS_TIMER_CONTROL_REG, 8'h03);
    wr_reg(iepx_pkg::OFS_IE, 8'h81);
    req_chk(1'b1, 4'h0, 1'b0);
    core(1'b1);
    rd_chk(iepx_pkg::OFS_TIMER_CONTROL_REG, 8'h01);
    core(1'b0);
    // Level request on input 1, held until vectored, dropped before return
    pins <= 8'hdc;
    settle();
    rd_chk(iepx_pkg::OFS_TIMER_CONTROL_REG, 8'h09);
    wr_reg(iepx_pkg::OFS_IE, 8'h84);
    req_chk(1'b1, 4'h2, 1'b0);
    core(1'b1);
    pins <= 8'hdd;
    core(1'b0);
    req_chk(1'b0, 4'h0, 1'b0);
    // Input 1 in edge mode and active high, then software clear and set of its flag
    wr_reg(iepx_pkg::OFS_TIMER_CONTROL_REG, 8'h04);
    wr_reg(iepx_pkg::OFS_CFG, 8'h8d);
    wr_reg(iepx_pkg::OFS_TIMER_CONTROL_REG, 8'h04);
    rd_chk(iepx_pkg::OFS_TIMER_CONTROL_REG, 8'h04);
    pins <= 8'hdc;
    settle();
    pins <= 8'hdd;
    settle();
    rd_chk(iepx_pkg::OFS_TIMER_CONTROL_REG, 8'h0c);
    req_chk(1'b1, 4'h2, 1'b0);
    wr_reg(iepx_pkg::OFS_TIMER_CONTROL_REG, 8'h04);
    rd_chk(iepx_pkg::OFS_TIMER_CONTROL_REG, 8'h04);
    wr_reg(iepx_pkg::OFS_TIMER_CONTROL_REG, 8'h0c);
    rd_chk(iepx_pkg::OFS_TIMER_CONTROL_REG, 8'h0c);
    stop_test();
  end
endmodule
`default_nettype wire

// [rtl/iepx_ext_if.sv]
// Configuration and pending flag link between the controller and an external input unit
`timescale 1ns/10ps
`default_nettype none
interface iepx_ext_if;
  logic [2:0] sel;
  logic pol;
  logic edge_mode;
  logic sw_wr;
  logic sw_val;
  logic vec_ack;
  logic pend;
  modport ctrl (output sel, pol, edge_mode, sw_wr, sw_val, vec_ack, input pend);
  modport unit (input sel, pol, edge_mode, sw_wr, sw_val, vec_ack, output pend);
endinterface
`default_nettype wire

// [rtl/iepx_ext_irq.sv]
// One external interrupt input: pin select, polarity, edge or level pending flag
`timescale 1ns/10ps
`default_nettype none
module iepx_ext_irq (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // Port 0 pins, only ever sampled
  input wire logic [7:0] pins_in,
  // Controller side
  iepx_ext_if.unit ext
);
  iepx_pkg::iepx_ext_s st_r, st_nxt;
  logic active;

  // Polarity: zero means active low
  assign active = pins_in[ext.sel] ~^ ext.pol;

  // Edge latches with set winning over clear; level mode just follows
  always_comb begin
    st_nxt = st_r;
    st_nxt.prev = active;
    if (ext.edge_mode) begin
      if (active && !st_r.prev) begin
        st_nxt.pend = 1'b1;
      end else if (ext.sw_wr) begin
        st_nxt.pend = ext.sw_val;
      end else if (ext.vec_ack) begin
        st_nxt.pend = 1'b0;
      end
    end else begin
      st_nxt.pend = active;
    end
  end

  // Prev starts inactive but follows the input while edge mode is off, so an input already active after reset is no edge
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ext.pend = st_r.pend;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  a_level_follows: assert property (!ext.edge_mode |=> st_r.pend == $past(active))
    else $error("level pending flag does not follow input");
  a_edge_sets: assert property (ext.edge_mode && active && !st_r.prev |=> st_r.pend)
    else $error("active edge did not set pending flag");
  a_edge_clears: assert property (ext.edge_mode && ext.vec_ack && !ext.sw_wr
      && !(active && !st_r.prev) |=> !st_r.pend)
    else $error("vectoring did not clear edge pending flag");
  c_edge_event: cover property (ext.edge_mode && active && !st_r.prev ##1 ext.vec_ack);
endmodule
`default_nettype wire

// [rtl/iepx_irq_ctrl.sv]
// Interrupt enable, priority, arbitration and external input front end
`timescale 1ns/10ps
`default_nettype none
module iepx_irq_ctrl #(
  parameter int SRC_COUNT = iepx_pkg::SRC_COUNT
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Port 0 pins sampled by the external inputs
  input wire logic [7:0] port0_pins_in,
  // Peripheral pending flags, levels held by each peripheral
  input wire logic timer_zero_flag_in,
  input wire logic timer_one_flag_in,
  input wire logic async_serial_flag_in,
  input wire logic timer_two_low_overflow_in,
  input wire logic timer_two_high_overflow_in,
  input wire logic serial_periph_flag_in,
  input wire logic two_wire_flag_in,
  input wire logic converter_done_flag_in,
  input wire logic counter_array_flag_in,
  input wire logic comparator_rise_flag_in,
  input wire logic comparator_fall_flag_in,
  input wire logic timer_three_low_overflow_in,
  input wire logic timer_three_high_overflow_in,
  // Core handshake
  input wire logic irq_ack_in,
  input wire logic irq_return_in,
  output logic irq_req_out,
  output logic [3:0] irq_id_out,
  output logic irq_high_out
);
  // Only the documented source count is served
  if (SRC_COUNT != iepx_pkg::SRC_COUNT) begin : g_bad_count
    $error("iepx_irq_ctrl serves exactly fifteen source positions");
  end

  iepx_pkg::iepx_state_s st_r, st_nxt;
  iepx_ext_if ext0 ();
  iepx_ext_if ext1 ();
  logic [SRC_COUNT-1:0] flag_v, en_v, prio_v, cand_v, hi_v;
  logic ins_lo_n, ins_hi_n;
  logic [7:0] ip_rd, timer_control_reg_rd;
  logic wr_timer_control_reg;

  // External input units
  iepx_ext_irq u_ext0 (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .pins_in(port0_pins_in),
    .ext(ext0)
  );
  iepx_ext_irq u_ext1 (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .pins_in(port0_pins_in),
    .ext(ext1)
  );

  // Configuration fields towards the units
  assign ext0.sel = st_r.cfg[iepx_pkg::CFG_SEL0 +: iepx_pkg::SEL_W];
  assign ext1.sel = st_r.cfg[iepx_pkg::CFG_SEL1 +: iepx_pkg::SEL_W];
  assign ext0.pol = st_r.cfg[iepx_pkg::CFG_POL0];
  assign ext1.pol = st_r.cfg[iepx_pkg::CFG_POL1];
  assign ext0.edge_mode = st_r.edge0;
  assign ext1.edge_mode = st_r.edge1;

  // Software access to the pending flags in timer control
  assign wr_timer_control_reg = reg_wr_in && (reg_addr_in == iepx_pkg::OFS_TIMER_CONTROL_REG);
  assign ext0.sw_wr = wr_timer_control_reg;
  assign ext1.sw_wr = wr_timer_control_reg;
  assign ext0.sw_val = reg_wdata_in[iepx_pkg::TC_PEND0];
  assign ext1.sw_val = reg_wdata_in[iepx_pkg::TC_PEND1];

  // Vectoring clears only the flag of the source being entered
  assign ext0.vec_ack = irq_ack_in && st_r.req && (st_r.id == iepx_pkg::ID_EXT0);
  assign ext1.vec_ack = irq_ack_in && st_r.req && (st_r.id == iepx_pkg::ID_EXT1);

  // Read images
  assign ip_rd = {1'b0, st_r.ip} | iepx_pkg::IP_ONE_MASK;
  assign timer_control_reg_rd = {4'h0, ext1.pend, st_r.edge1, ext0.pend, st_r.edge0};

  // Source flags by fixed order number
  always_comb begin
    flag_v = '0;
    flag_v[0] = ext0.pend;
    flag_v[1] = timer_zero_flag_in;
    flag_v[2] = ext1.pend;
    flag_v[3] = timer_one_flag_in;
    flag_v[4] = async_serial_flag_in;
    flag_v[5] = timer_two_low_overflow_in | timer_two_high_overflow_in;
    flag_v[6] = serial_periph_flag_in;
    flag_v[iepx_pkg::ID_TWO_WIRE] = two_wire_flag_in;
    flag_v[iepx_pkg::ID_CONV] = converter_done_flag_in;
    flag_v[iepx_pkg::ID_PCA] = counter_array_flag_in;
    flag_v[iepx_pkg::ID_CMP] = comparator_rise_flag_in | comparator_fall_flag_in;
    flag_v[iepx_pkg::ID_T3] = timer_three_low_overflow_in | timer_three_high_overflow_in;
  end

  // Enable and priority bits by order number; reserved positions stay dead
  always_comb begin
    en_v = '0;
    prio_v = '0;
    en_v[iepx_pkg::BASIC_SRCS-1:0] = st_r.ie[iepx_pkg::BASIC_SRCS-1:0];
    prio_v[iepx_pkg::BASIC_SRCS-1:0] = st_r.ip;
    en_v[iepx_pkg::ID_TWO_WIRE] = st_r.eie[iepx_pkg::EX_TWO_WIRE];
    en_v[iepx_pkg::ID_CONV] = st_r.eie[iepx_pkg::EX_CONV];
    en_v[iepx_pkg::ID_PCA] = st_r.eie[iepx_pkg::EX_PCA];
    en_v[iepx_pkg::ID_CMP] = st_r.eie[iepx_pkg::EX_CMP];
    en_v[iepx_pkg::ID_T3] = st_r.eie[iepx_pkg::EX_T3];
    prio_v[iepx_pkg::ID_TWO_WIRE] = st_r.eip[iepx_pkg::EX_TWO_WIRE];
    prio_v[iepx_pkg::ID_CONV] = st_r.eip[iepx_pkg::EX_CONV];
    prio_v[iepx_pkg::ID_PCA] = st_r.eip[iepx_pkg::EX_PCA];
    prio_v[iepx_pkg::ID_CMP] = st_r.eip[iepx_pkg::EX_CMP];
    prio_v[iepx_pkg::ID_T3] = st_r.eip[iepx_pkg::EX_T3];
  end

  // Gating: global enable first, then each mask; blocked flags remain pending
  assign cand_v = st_r.ie[iepx_pkg::GLB_BIT] ? (flag_v & en_v) : '0;
  // Priority mask comes after gating, so a disabled high source never blocks
  assign hi_v = cand_v & prio_v;

  // In-service levels after this cycle's acknowledge and return
  always_comb begin
    ins_lo_n = st_r.ins_lo;
    ins_hi_n = st_r.ins_hi;
    // Return before acknowledge, so a same-cycle pair still nests correctly
    if (irq_return_in) begin
      if (st_r.ins_hi) begin
        ins_hi_n = 1'b0;
      end else begin
        ins_lo_n = 1'b0;
      end
    end
    if (irq_ack_in && st_r.req) begin
      if (st_r.lvl) begin
        ins_hi_n = 1'b1;
      end else begin
        ins_lo_n = 1'b1;
      end
    end
  end

  // Registers, read data and arbitration
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = 8'h00;
    // Writes take effect on the strobe edge
    if (reg_wr_in) begin
      case (reg_addr_in)
        iepx_pkg::OFS_IE: begin
          st_nxt.ie = reg_wdata_in;
        end
        iepx_pkg::OFS_IP: begin
          st_nxt.ip = reg_wdata_in[iepx_pkg::BASIC_SRCS-1:0];
        end
        iepx_pkg::OFS_CFG: begin
          st_nxt.cfg = reg_wdata_in;
        end
        iepx_pkg::OFS_EIE: begin
          st_nxt.eie = reg_wdata_in & iepx_pkg::EXT_RW_MASK;
        end
        iepx_pkg::OFS_EIP: begin
          st_nxt.eip = reg_wdata_in & iepx_pkg::EXT_RW_MASK;
        end
        iepx_pkg::OFS_TIMER_CONTROL_REG: begin
          st_nxt.edge0 = reg_wdata_in[iepx_pkg::TC_EDGE0];
          st_nxt.edge1 = reg_wdata_in[iepx_pkg::TC_EDGE1];
        end
        default: begin
        end
      endcase
    end
    // Read data stand one cycle after the strobe; unmapped reads zero
    if (reg_rd_in) begin
      case (reg_addr_in)
        iepx_pkg::OFS_IE: begin
          st_nxt.rdata = st_r.ie;
        end
        iepx_pkg::OFS_IP: begin
          st_nxt.rdata = ip_rd;
        end
        iepx_pkg::OFS_CFG: begin
          st_nxt.rdata = st_r.cfg;
        end
        iepx_pkg::OFS_EIE: begin
          st_nxt.rdata = st_r.eie & iepx_pkg::EXT_RW_MASK;
        end
        iepx_pkg::OFS_EIP: begin
          st_nxt.rdata = st_r.eip & iepx_pkg::EXT_RW_MASK;
        end
        iepx_pkg::OFS_TIMER_CONTROL_REG: begin
          st_nxt.rdata = timer_control_reg_rd;
        end
        default: begin
          st_nxt.rdata = 8'h00;
        end
      endcase
    end
    // In-service levels as worked out above
    st_nxt.ins_lo = ins_lo_n;
    st_nxt.ins_hi = ins_hi_n;
    // Lowest order number wins within a level; scan downward so the last hit stands
    st_nxt.req = 1'b0;
    st_nxt.id = 4'h0;
    st_nxt.lvl = 1'b0;
    for (int i = SRC_COUNT - 1; i >= 0; i--) begin
      if (cand_v[i] && !(|hi_v)) begin
        st_nxt.id = i[iepx_pkg::ID_W-1:0];
      end
      if (hi_v[i]) begin
        st_nxt.id = i[iepx_pkg::ID_W-1:0];
      end
    end
    // A high routine blocks everything; a low routine lets only high through
    if (|hi_v && !ins_hi_n) begin
      st_nxt.req = 1'b1;
      st_nxt.lvl = 1'b1;
    end else if (|cand_v && !ins_hi_n && !ins_lo_n) begin
      st_nxt.req = 1'b1;
    end
    // An acknowledged request is withdrawn for one cycle while its flag clears
    if (irq_ack_in && st_r.req) begin
      st_nxt.req = 1'b0;
    end
  end

  // Single state register
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= '{ie: iepx_pkg::RST_IE, ip: iepx_pkg::RST_IP[6:0], cfg: iepx_pkg::RST_CFG,
                eie: iepx_pkg::RST_EIE, eip: iepx_pkg::RST_EIP, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata_out = st_r.rdata;
  assign irq_req_out = st_r.req;
  assign irq_id_out = st_r.id;
  assign irq_high_out = st_r.lvl;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  // Gating: every request traces back to an enabled source whose flag stood
  a_global_gate: assert property (!st_r.ie[iepx_pkg::GLB_BIT] |=> !irq_req_out)
    else $error("request raised with global enable off");
  // Index by the id now shown, not by the id registered a cycle earlier
  a_mask_gate: assert property (irq_req_out
      |-> (($past(en_v & flag_v) >> irq_id_out) & 15'h0001) != 15'h0000)
    else $error("request raised for a masked or idle source");
  // A flag held back only by the global enable is served once it returns
  a_pending_served: assert property (st_r.ie[iepx_pkg::GLB_BIT] && |(flag_v & en_v)
      && !st_r.ins_lo && !st_r.ins_hi && !irq_ack_in |=> irq_req_out)
    else $error("eligible pending source not requested");
  // Twin-flag sources pass on either flag; the converter only on its own
  a_timer2_either: assert property (irq_req_out && irq_id_out == iepx_pkg::ID_T2
      |-> $past(timer_two_low_overflow_in || timer_two_high_overflow_in))
    else $error("timer 2 request without overflow flag");
  a_cmp_either: assert property (irq_req_out && irq_id_out == iepx_pkg::ID_CMP
      |-> $past(comparator_rise_flag_in || comparator_fall_flag_in))
    else $error("comparator request without edge flag");
  a_timer3_either: assert property (irq_req_out && irq_id_out == iepx_pkg::ID_T3
      |-> $past(timer_three_low_overflow_in || timer_three_high_overflow_in))
    else $error("timer 3 request without overflow flag");
  a_conv_only: assert property (irq_req_out && irq_id_out == iepx_pkg::ID_CONV
      |-> $past(converter_done_flag_in))
    else $error("converter request without complete flag");
  // Register images and write paths
  a_ip_top_one: assert property (reg_rd_in && reg_addr_in == iepx_pkg::OFS_IP
      |=> reg_rdata_out[iepx_pkg::GLB_BIT])
    else $error("basic priority bit 7 read as zero");
  a_reserved_zero: assert property (reg_rd_in && (reg_addr_in == iepx_pkg::OFS_EIE
      || reg_addr_in == iepx_pkg::OFS_EIP)
      |=> (reg_rdata_out & ~iepx_pkg::EXT_RW_MASK) == 8'h00)
    else $error("reserved extended bits read nonzero");
  a_cfg_write: assert property (reg_wr_in && reg_addr_in == iepx_pkg::OFS_CFG
      |=> st_r.cfg == $past(reg_wdata_in))
    else $error("configuration write not taken");
  a_ie_write: assert property (reg_wr_in && reg_addr_in == iepx_pkg::OFS_IE
      |=> st_r.ie == $past(reg_wdata_in))
    else $error("basic enable write not taken");
  a_eie_write: assert property (reg_wr_in && reg_addr_in == iepx_pkg::OFS_EIE
      |=> st_r.eie == ($past(reg_wdata_in) & iepx_pkg::EXT_RW_MASK))
    else $error("extended enable write not taken");
  // Pending flags must show in the timer control image
  a_timer_control_reg_pending: assert property (reg_rd_in && reg_addr_in == iepx_pkg::OFS_TIMER_CONTROL_REG
      |=> reg_rdata_out[iepx_pkg::TC_PEND0] == $past(ext0.pend)
      && reg_rdata_out[iepx_pkg::TC_PEND1] == $past(ext1.pend))
    else $error("pending flags missing from timer control image");
  // Read data stand for the answer cycle only; otherwise the port idles at zero
  a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data outside the answer cycle");
  // A return in this cycle lifts the high block for the next one
  a_high_blocks: assert property (st_r.ins_hi && !irq_return_in |=> !irq_req_out)
    else $error("request raised during a high routine");
  a_low_preempt: assert property (st_r.ins_lo && irq_req_out |-> irq_high_out)
    else $error("low request raised during a low routine");
  // The level now shown tells which candidate set the winner came from
  a_fixed_order: assert property (irq_req_out
      |-> ((irq_high_out ? $past(hi_v) : $past(cand_v))
      & ((15'h0001 << irq_id_out) - 15'h0001)) == 15'h0000)
    else $error("lower numbered request passed over");

  // Main scenarios
  c_read_access: cover property (reg_rd_in ##1 reg_rdata_out != 8'h00);
  c_preempt: cover property (st_r.ins_lo && irq_req_out && irq_high_out ##1 irq_ack_in);
  c_vector_ext0: cover property (irq_req_out && irq_id_out == iepx_pkg::ID_EXT0 && irq_ack_in);
  c_nested_levels: cover property (st_r.ins_lo && st_r.ins_hi);
endmodule
`default_nettype wire

// [rtl/iepx_pkg.sv]
// Constants, register map and state types of the interrupt enable and priority block
package iepx_pkg;
  // Register byte addresses
  localparam logic [7:0] OFS_IE = 8'ha8;
  localparam logic [7:0] OFS_IP = 8'hb8;
  localparam logic [7:0] OFS_CFG = 8'he4;
  localparam logic [7:0] OFS_EIE = 8'he6;
  localparam logic [7:0] OFS_EIP = 8'hf6;
  localparam logic [7:0] OFS_TIMER_CONTROL_REG = 8'h88;
  // Reset values
  localparam logic [7:0] RST_IE = 8'h00;
  localparam logic [7:0] RST_IP = 8'h80;
  localparam logic [7:0] RST_CFG = 8'h01;
  localparam logic [7:0] RST_EIE = 8'h00;
  localparam logic [7:0] RST_EIP = 8'h00;
  // Writable bits of the extended pair, reserved ones stay zero
  localparam logic [7:0] EXT_RW_MASK = 8'hb9;
  // Basic priority top bit always reads one
  localparam logic [7:0] IP_ONE_MASK = 8'h80;
  localparam int GLB_BIT = 7;
  // Extended enable and priority bit positions
  localparam int EX_TWO_WIRE = 0;
  localparam int EX_CONV = 3;
  localparam int EX_PCA = 4;
  localparam int EX_CMP = 5;
  localparam int EX_T3 = 7;
  // Timer control low nibble
  localparam int TC_EDGE0 = 0;
  localparam int TC_PEND0 = 1;
  localparam int TC_EDGE1 = 2;
  localparam int TC_PEND1 = 3;
  // External configuration fields
  localparam int CFG_POL1 = 7;
  localparam int CFG_SEL1 = 4;
  localparam int CFG_POL0 = 3;
  localparam int CFG_SEL0 = 0;
  localparam int SEL_W = 3;
  // Fixed source order numbers
  localparam int SRC_COUNT = 15;
  localparam int ID_W = 4;
  localparam logic [3:0] ID_EXT0 = 4'h0;
  localparam logic [3:0] ID_EXT1 = 4'h2;
  localparam logic [3:0] ID_T2 = 4'h5;
  localparam logic [3:0] ID_TWO_WIRE = 4'h7;
  localparam logic [3:0] ID_CONV = 4'ha;
  localparam logic [3:0] ID_PCA = 4'hb;
  localparam logic [3:0] ID_CMP = 4'hc;
  localparam logic [3:0] ID_T3 = 4'he;
  localparam int BASIC_SRCS = 7;

  // Main block state
  typedef struct packed {
    logic [7:0] ie;
    logic [6:0] ip;
    logic [7:0] cfg;
    logic [7:0] eie;
    logic [7:0] eip;
    logic edge0;
    logic edge1;
    logic [7:0] rdata;
    logic req;
    logic [3:0] id;
    logic lvl;
    logic ins_lo;
    logic ins_hi;
  } iepx_state_s;

  // External input unit state
  typedef struct packed {
    logic prev;
    logic pend;
  } iepx_ext_s;
endpackage
